//--- pkg/epvu_pkg.sv
// Purpose: Constants and types shared by the event priority vector unit
// Assumes: Rank index 0..27 stands for priorities 1..28
// Notes: Handler offsets are combined with the vector base by OR
package epvu_pkg;

  // ----------------------------------------------------------------
  // Rank indices (priority minus one)
  // ----------------------------------------------------------------
  localparam int unsigned NUM_RANKS = 28;
  localparam logic [4:0] RK_RESET = 5'h00; // Priority 1
  localparam logic [4:0] RK_DBG_STOP = 5'h01; // Priority 2
  localparam logic [4:0] RK_UNRECOV = 5'h02;
  localparam logic [4:0] RK_MULTI_HIT = 5'h03;
  localparam logic [4:0] RK_BUS_DATA = 5'h04;
  localparam logic [4:0] RK_BUS_INSN = 5'h05;
  localparam logic [4:0] RK_NMI = 5'h06;
  localparam logic [4:0] RK_INT3 = 5'h07;
  localparam logic [4:0] RK_INT0 = 5'h0A;
  localparam logic [4:0] RK_BREAK = 5'h0E;
  localparam logic [4:0] RK_FLOAT = 5'h12; // Never raised
  localparam logic [4:0] RK_SCALL = 5'h14;
  localparam logic [4:0] RK_DATA_MOD = 5'h1B; // Never raised

  // ----------------------------------------------------------------
  // Handler addresses and offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
  localparam logic [31:0] OFF_UNRECOV = 32'h0000_0000;
  localparam logic [31:0] OFF_MULTI_HIT = 32'h0000_0004;
  localparam logic [31:0] OFF_BUS_DATA = 32'h0000_0008;
  localparam logic [31:0] OFF_BUS_INSN = 32'h0000_000C;
  localparam logic [31:0] OFF_NMI = 32'h0000_0010;
  localparam logic [31:0] OFF_INSN_ADDR = 32'h0000_0014;
  localparam logic [31:0] OFF_IMISS = 32'h0000_0050;
  localparam logic [31:0] OFF_IPROT = 32'h0000_0018;
  localparam logic [31:0] OFF_BREAK = 32'h0000_001C;
  localparam logic [31:0] OFF_ILL_OPC = 32'h0000_0020;
  localparam logic [31:0] OFF_UNIMPL = 32'h0000_0024;
  localparam logic [31:0] OFF_PRIV = 32'h0000_0028;
  localparam logic [31:0] OFF_FLOAT = 32'h0000_002C; // Reserved
  localparam logic [31:0] OFF_COPROC = 32'h0000_0030;
  localparam logic [31:0] OFF_SCALL = 32'h0000_0100;
  localparam logic [31:0] OFF_DADDR_RD = 32'h0000_0034;
  localparam logic [31:0] OFF_DADDR_WR = 32'h0000_0038;
  localparam logic [31:0] OFF_DMISS_RD = 32'h0000_0060;
  localparam logic [31:0] OFF_DMISS_WR = 32'h0000_0070;
  localparam logic [31:0] OFF_DPROT_RD = 32'h0000_003C;
  localparam logic [31:0] OFF_DPROT_WR = 32'h0000_0040;
  localparam logic [31:0] OFF_DATA_MOD = 32'h0000_0044; // Reserved
  localparam logic [31:0] SCALL_STEP = 32'h0000_0002;

  // ----------------------------------------------------------------
  // Mask bit positions and reset value
  // ----------------------------------------------------------------
  localparam int unsigned MB_GM = 0;
  localparam int unsigned MB_I0M = 1; // I1M..I3M follow upward
  localparam int unsigned MB_EM = 5;
  localparam int unsigned MB_DM = 6;
  localparam logic [6:0] MASK_RST = 7'h01;

  // Fixed offset for exception ranks; interrupt ranks never use it
  function automatic logic [31:0] epvu_offset(input logic [4:0] rk);
    logic [31:0] off;
    off = OFF_UNRECOV;
    unique case (rk)
      5'h03: off = OFF_MULTI_HIT;
      5'h04: off = OFF_BUS_DATA;
      5'h05: off = OFF_BUS_INSN;
      5'h06: off = OFF_NMI;
      5'h0B: off = OFF_INSN_ADDR;
      5'h0C: off = OFF_IMISS;
      5'h0D: off = OFF_IPROT;
      5'h0E: off = OFF_BREAK;
      5'h0F: off = OFF_ILL_OPC;
      5'h10: off = OFF_UNIMPL;
      5'h11: off = OFF_PRIV;
      5'h12: off = OFF_FLOAT;
      5'h13: off = OFF_COPROC;
      5'h14: off = OFF_SCALL;
      5'h15: off = OFF_DADDR_RD;
      5'h16: off = OFF_DADDR_WR;
      5'h17: off = OFF_DMISS_RD;
      5'h18: off = OFF_DMISS_WR;
      5'h19: off = OFF_DPROT_RD;
      5'h1A: off = OFF_DPROT_WR;
      5'h1B: off = OFF_DATA_MOD;
      default: off = OFF_UNRECOV;
    endcase
    return off;
  endfunction

  // Controller states
  typedef enum logic [0:0] {EPVU_IDLE, EPVU_BUSY} epvu_state_t;

endpackage

//--- verilog/epvu_rank_pick.sv
// Purpose: Picks the highest priority pending rank of one instruction
// Assumes: Bit 0 of the pending vector is the highest priority
// Notes: Purely combinational, used once per pipeline stage
`timescale 1ns/1ps
`default_nettype none

module epvu_rank_pick
  import epvu_pkg::*;
(
  // Pending events of one instruction
  input wire logic [NUM_RANKS-1:0] pend_in,
  // Result
  output logic hit_out,
  output logic [4:0] rank_out
);

  // ----------------------------------------------------------------
  // Priority scan
  // ----------------------------------------------------------------
  // Scan from lowest priority upward so the best rank is written last
  always_comb begin
    hit_out = 1'b0;
    rank_out = 5'h00;
    for (int i = NUM_RANKS - 1; i >= 0; i--) begin
      if (pend_in[i]) begin
        hit_out = 1'b1;
        rank_out = 5'(i); // [RULE1]
      end
    end
  end

endmodule

`default_nettype wire

//--- verilog/event_priority_vector_unit.sv
// Purpose: Resolves pending core events and forms the handler address
// Assumes: Sources hold events pending until accepted; core pulses done
// Notes: One accepted event at a time, except reset; results come from flip-flops
//
// What this block does
// RULE1: Fixed 28-rank order picks the winning event
// RULE2: Data bus error vectors base+0x08, resume address
// RULE3: Instruction bus error vectors base+0x0C, resume address
// RULE4: Debug stop takes handler from debug unit
// RULE5: Instruction faults save own PC; scall base+0x100
// RULE6: Interrupt handler is base OR 14-bit offset
// RULE7: Accepting sets masks of equal/lower sources
// RULE8: Oldest instruction's events served before younger ones
// RULE9: Floating-point and data-modified slots never raised
`timescale 1ns/1ps
`default_nettype none

module event_priority_vector_unit
  import epvu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Older instruction: pending events and its address
  input wire logic [NUM_RANKS-1:0] old_pend_in,
  input wire logic [31:0] old_pc_in,
  // Younger instruction: pending events and its address
  input wire logic [NUM_RANKS-1:0] yng_pend_in,
  input wire logic [31:0] yng_pc_in,
  // Pipeline state
  input wire logic [31:0] resume_pc_in,
  input wire logic done_in,
  // Vector sources
  input wire logic [31:0] event_vector_base_in,
  input wire logic [31:0] on_chip_debug_unit_addr_in,
  input wire logic [13:0] autovec_off_in,
  // Status register mask write from the core
  input wire logic mask_wr_in,
  input wire logic [6:0] mask_wr_data_in,
  // Results to the core
  output logic take_out,
  output logic [4:0] rank_out,
  output logic [31:0] handler_addr_out,
  output logic [31:0] ret_addr_out,
  output logic [6:0] mask_out,
  output logic busy_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    epvu_state_t st; // Idle or waiting for the core
    logic take; // Acceptance pulse
    logic [4:0] rank; // Accepted rank index
    logic [31:0] handler; // Handler address
    logic [31:0] ret; // Return address
    logic [6:0] mask; // Status mask bits
  } epvu_regs_t;

  epvu_regs_t regs_r; // Registered state
  epvu_regs_t regs_nxt; // Next state

  logic [NUM_RANKS-1:0] old_live; // Older stage after masking
  logic [NUM_RANKS-1:0] yng_live; // Younger stage after masking
  logic old_hit; // Older stage has an event
  logic yng_hit; // Younger stage has an event
  logic [4:0] old_rank; // Best rank of older stage
  logic [4:0] yng_rank; // Best rank of younger stage

  // ----------------------------------------------------------------
  // Masking of pending events
  // ----------------------------------------------------------------
  // Critical events bypass every mask; unused slots are forced low
  function automatic logic [NUM_RANKS-1:0] live_of(
      input logic [NUM_RANKS-1:0] p, input logic [6:0] m);
    logic [NUM_RANKS-1:0] v;
    v = p;
    v[RK_FLOAT] = 1'b0; // [RULE9]
    v[RK_DATA_MOD] = 1'b0; // [RULE9]
    if (m[MB_DM]) begin
      v[RK_DBG_STOP] = 1'b0;
      v[RK_BREAK] = 1'b0;
    end
    // Level n sits at rank index RK_INT0 - n
    for (int n = 0; n < 4; n++) begin
      if (m[MB_GM] || m[MB_I0M + n]) begin
        v[RK_INT0 - 5'(n)] = 1'b0;
      end
    end
    return v;
  endfunction

  assign old_live = live_of(old_pend_in, regs_r.mask);
  assign yng_live = live_of(yng_pend_in, regs_r.mask);

  // ----------------------------------------------------------------
  // Per-stage priority pick
  // ----------------------------------------------------------------
  epvu_rank_pick u_pick_old (
    .pend_in(old_live),
    .hit_out(old_hit),
    .rank_out(old_rank)
  );

  epvu_rank_pick u_pick_yng (
    .pend_in(yng_live),
    .hit_out(yng_hit),
    .rank_out(yng_rank)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic win; // An event is taken this cycle
    logic [4:0] rk; // Winning rank
    logic [31:0] pc; // Address of the winning instruction
    logic [6:0] setm; // Mask bits set by acceptance
    regs_nxt = regs_r;
    regs_nxt.take = 1'b0;
    win = 1'b0;
    rk = 5'h00;
    pc = 32'h0000_0000;
    setm = 7'h00;
    // Older instruction wins whatever the younger one holds
    if (old_hit) begin
      rk = old_rank; // [RULE8]
      pc = old_pc_in;
    end else begin
      rk = yng_rank; // [RULE8]
      pc = yng_pc_in;
    end
    // Reset is never blocked by a pending handshake
    if (rk == RK_RESET && (old_hit || yng_hit)) begin
      win = 1'b1; // [RULE1]
    end else if (regs_r.st == EPVU_IDLE) begin
      win = old_hit || yng_hit;
    end
    // Masks of equal or lower priority sources
    if (rk == RK_DBG_STOP) begin
      setm[MB_DM] = 1'b1; // [RULE7]
    end else if (rk != RK_RESET) begin
      for (int n = 0; n < 4; n++) begin
        if (RK_INT0 - 5'(n) >= rk) begin
          setm[MB_I0M + n] = 1'b1; // [RULE7]
        end
      end
      setm[MB_EM] = 1'b1; // [RULE7]
      if (rk < RK_INT3 || rk > RK_INT0) begin
        setm[MB_GM] = 1'b1; // [RULE7]
      end
    end
    // Core mask write; acceptance set wins over the write
    if (mask_wr_in) begin
      regs_nxt.mask = mask_wr_data_in;
    end
    if (done_in) begin
      regs_nxt.st = EPVU_IDLE;
    end
    if (win) begin
      regs_nxt.st = EPVU_BUSY;
      regs_nxt.take = 1'b1;
      regs_nxt.rank = rk;
      regs_nxt.mask = regs_nxt.mask | setm; // [RULE7]
      if (rk == RK_RESET) begin
        regs_nxt.mask = MASK_RST;
      end
      // Handler address
      unique case (rk)
        RK_RESET: begin
          regs_nxt.handler = RESET_ADDR;
        end
        RK_DBG_STOP: begin
          regs_nxt.handler = on_chip_debug_unit_addr_in; // [RULE4]
        end
        RK_INT3, 5'h08, 5'h09, RK_INT0: begin
          // OR, not add: base must be aligned by software
          regs_nxt.handler = event_vector_base_in |
            {18'h0_0000, autovec_off_in}; // [RULE6]
        end
        default: begin
          // Bus errors, NMI, faults and supervisor call
          regs_nxt.handler = event_vector_base_in |
            epvu_offset(rk); // [RULE2] [RULE3] [RULE5]
        end
      endcase
      // Return address
      unique case (rk)
        RK_RESET: begin
          regs_nxt.ret = 32'h0000_0000;
        end
        RK_SCALL: begin
          regs_nxt.ret = pc + SCALL_STEP; // [RULE5]
        end
        RK_UNRECOV, RK_MULTI_HIT, 5'h0B, 5'h0C, 5'h0D, 5'h0F, 5'h10,
        5'h11, 5'h13, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A: begin
          regs_nxt.ret = pc; // [RULE5]
        end
        default: begin
          // Bus errors, debug, NMI, interrupts, breakpoint
          regs_nxt.ret = resume_pc_in; // [RULE2] [RULE3]
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      regs_r.st <= EPVU_IDLE;
      regs_r.take <= 1'b0;
      regs_r.rank <= 5'h00;
      regs_r.handler <= 32'h0000_0000;
      regs_r.ret <= 32'h0000_0000;
      regs_r.mask <= MASK_RST;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign take_out = regs_r.take;
  assign rank_out = regs_r.rank;
  assign handler_addr_out = regs_r.handler;
  assign ret_addr_out = regs_r.ret;
  assign mask_out = regs_r.mask;
  assign busy_out = (regs_r.st == EPVU_BUSY);

endmodule

`default_nettype wire

//--- tb/epvu_core_model.sv
// Purpose: Core and debug side seen by the event priority vector unit
// Assumes: One take_out pulse per accepted event
// Notes: Answers promptly or slowly as slow_in selects
`timescale 1ns/1ps
`default_nettype none
module epvu_core_model #(
  parameter logic [31:0] DBG_ADDR = 32'h0000_7700
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // From the unit
  input wire logic take_in,
  input wire logic slow_in,
  // To the unit
  output logic done_out,
  output logic [31:0] dbg_addr_out
);
  logic [2:0] cnt_r; // Cycles left before done
  // ----------------------------------------------------------------
  // Debug handler address, always on offer
  // ----------------------------------------------------------------
  assign dbg_addr_out = DBG_ADDR;
  // Redirect finishes a few cycles after a take
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      cnt_r <= 3'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt_r == 3'h1);
      if (take_in) begin
        cnt_r <= slow_in ? 3'h4 : 3'h1;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/epvu_chk.sv
// Purpose: Port checks of the event priority vector unit
// Assumes: One clock, synchronous active-low reset
// Notes: Addresses are judged against inputs of the accepting edge
`timescale 1ns/1ps
`default_nettype none
module epvu_chk
  import epvu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // Inputs watched
  input wire logic [NUM_RANKS-1:0] old_pend_in,
  input wire logic [NUM_RANKS-1:0] yng_pend_in,
  input wire logic done_in,
  input wire logic [31:0] event_vector_base_in,
  input wire logic [31:0] on_chip_debug_unit_addr_in,
  input wire logic [13:0] autovec_off_in,
  // Outputs watched
  input wire logic take_out,
  input wire logic [4:0] rank_out,
  input wire logic [31:0] handler_addr_out,
  input wire logic [6:0] mask_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  logic rp; // Reset event may be retaken while busy
  assign rp = old_pend_in[0] | yng_pend_in[0];
  logic [31:0] pb; // Base of the accepting edge
  always_ff @(posedge clk_sys_in) pb <= event_vector_base_in;
  property p_pulse;
    take_out && !rp |=> !take_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("take too long");
  property p_free;
    busy_out && done_in && !rp |=> !busy_out && !take_out;
  endproperty
  a_free: assert property (p_free) else $error("not freed");
  property p_busd;
    take_out && rank_out == 5'h04 |->
      handler_addr_out == (pb | 32'h0000_0008);
  endproperty
  a_busd: assert property (p_busd) else $error("data bus vec");
  property p_busi;
    take_out && rank_out == 5'h05 |->
      handler_addr_out == (pb | 32'h0000_000C);
  endproperty
  a_busi: assert property (p_busi) else $error("insn bus vec");
  property p_dbg;
    take_out && rank_out == 5'h01 |->
      handler_addr_out == $past(on_chip_debug_unit_addr_in);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug vec");
  property p_scall;
    take_out && rank_out == 5'h14 |->
      handler_addr_out == (pb | 32'h0000_0100);
  endproperty
  a_scall: assert property (p_scall) else $error("scall vec");
  property p_int;
    take_out && rank_out inside {[5'h07:5'h0A]} |->
      handler_addr_out == (pb | {18'h0_0000, $past(autovec_off_in)});
  endproperty
  a_int: assert property (p_int) else $error("autovector");
  property p_mask;
    take_out && rank_out == 5'h04 |-> (mask_out & 7'h3F) == 7'h3F;
  endproperty
  a_mask: assert property (p_mask) else $error("mask set");
  property p_unused;
    take_out |-> rank_out != 5'h12 && rank_out != 5'h1B;
  endproperty
  a_unused: assert property (p_unused) else $error("unused slot");
  // Main scenarios reached
  c_bus: cover property (take_out && rank_out == 5'h04);
  c_int: cover property (take_out && rank_out == 5'h07);
  c_dbg: cover property (take_out && rank_out == 5'h01);
endmodule
bind event_priority_vector_unit epvu_chk u_chk (.*);
`default_nettype wire

//--- tb/event_priority_vector_unit_bench.sv
// Purpose: Self-checking bench of the event priority vector unit
// Assumes: Core model pulses done after each take
// Notes: Sources hold events until taken, then drop them
`timescale 1ns/1ps
`default_nettype none
module event_priority_vector_unit_bench;
  import epvu_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [27:0] op = 28'h000_0000;
  logic [27:0] yp = 28'h000_0000;
  logic [31:0] opc = 32'h0000_0400;
  logic [31:0] ypc = 32'h0000_0800;
  logic [31:0] rpc = 32'h0000_0600;
  logic [31:0] base = 32'h0000_2000;
  logic [13:0] avo = 14'h0004;
  logic mw = 1'b0;
  logic [6:0] md = 7'h00;
  logic slow = 1'b0;
  wire logic done, take, busy;
  wire logic [4:0] rank;
  wire logic [31:0] hnd, ret, dbg;
  wire logic [6:0] mask;
  int bad_count = 0;
  int compares = 0;
  event_priority_vector_unit DUT (.clk_sys_in(clk), .rst_b_in(rst_b),
    .old_pend_in(op), .old_pc_in(opc), .yng_pend_in(yp), .yng_pc_in(ypc),
    .resume_pc_in(rpc), .done_in(done), .event_vector_base_in(base),
    .on_chip_debug_unit_addr_in(dbg), .autovec_off_in(avo),
    .mask_wr_in(mw), .mask_wr_data_in(md), .take_out(take),
    .rank_out(rank), .handler_addr_out(hnd), .ret_addr_out(ret),
    .mask_out(mask), .busy_out(busy));
  epvu_core_model u_core (.clk_sys_in(clk), .rst_b_in(rst_b),
    .take_in(take), .slow_in(slow), .done_out(done), .dbg_addr_out(dbg));
  initial begin
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Raise events and wait for the take; drop clears them and waits for busy to fall
  task automatic fire(input logic [27:0] o, y);
    int n;
    n = 0;
    @(posedge clk);
    op <= o;
    yp <= y;
    while (take !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("take_out", take, 32'h0000_0001);
  endtask
  task automatic drop();
    int n;
    n = 0;
    @(posedge clk);
    op <= 28'h000_0000;
    yp <= 28'h000_0000;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("busy_out", busy, 32'h0000_0000);
  endtask
  task automatic res(input logic [4:0] r, input logic [31:0] h, a);
    chk("rank_out", rank, r);
    chk("handler_addr_out", hnd, h);
    chk("ret_addr_out", ret, a);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_rst();
    fire(28'h000_0011, 28'h000_0000);
    chk("rank_out", rank, 32'h0000_0000);
    chk("mask_out", mask, 32'h0000_0001);
    chk("handler_addr_out", hnd, 32'h8000_0000);
    drop();
    $display("test reset done");
  endtask
  task automatic t_bus();
    fire(28'h000_8030, 28'h000_0000);
    res(5'h04, 32'h0000_2008, 32'h0000_0600);
    chk("mask_out", mask & 7'h3F, 32'h0000_003F);
    drop();
    fire(28'h000_8020, 28'h000_0000);
    res(5'h05, 32'h0000_200C, 32'h0000_0600);
    drop();
    $display("test bus done");
  endtask
  task automatic t_dbg();
    slow <= 1'b1;
    fire(28'h000_0006, 28'h000_0000);
    res(5'h01, 32'h0000_7700, 32'h0000_0600);
    drop();
    slow <= 1'b0;
    $display("test debug done");
  endtask
  task automatic t_fault();
    // Debug stop pending too, but the debug mask set earlier holds it
    fire(28'h000_0006, 28'h000_0000);
    res(5'h02, 32'h0000_2000, 32'h0000_0400);
    drop();
    fire(28'h000_1000, 28'h000_0000);
    res(5'h0C, 32'h0000_2050, 32'h0000_0400);
    drop();
    fire(28'h010_0000, 28'h000_0000);
    res(5'h14, 32'h0000_2100, 32'h0000_0402);
    drop();
    fire(28'h200_0000, 28'h000_0040);
    res(5'h19, 32'h0000_203C, 32'h0000_0400);
    drop();
    $display("test fault done");
  endtask
  task automatic t_int();
    @(posedge clk);
    mw <= 1'b1;
    base <= 32'h0001_0004;
    @(posedge clk);
    mw <= 1'b0;
    fire(28'h000_0480, 28'h000_0000);
    res(5'h07, 32'h0001_0004, 32'h0000_0600);
    chk("mask_out", mask, 32'h0000_003E);
    drop();
    @(posedge clk);
    op <= 28'h804_0100;
    repeat (8) @(negedge clk);
    chk("rank_out", rank, 32'h0000_0007);
    chk("take_out", take, 32'h0000_0000);
    drop();
    $display("test interrupt done");
  endtask
  // Mid-run reset returns every output to its idle value
  task automatic t_pin_rst();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("take_out", take, 32'h0000_0000);
    res(5'h00, 32'h0000_0000, 32'h0000_0000);
    chk("mask_out", mask, 32'h0000_0001);
    chk("busy_out", busy, 32'h0000_0000);
    $display("test reset pin done");
  endtask
  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_rst();
    t_bus();
    t_dbg();
    t_fault();
    t_int();
    t_pin_rst();
    give_verdict();
  end
endmodule
`default_nettype wire
